// *** hw/kms_scanner.sv ***
// Keypad matrix scanner: idle detection, debounce, column scan, results,
// Avalon-MM register slave and a level interrupt.
// Assumes row pins are pulled down outside and columns are tri-state pads.
//
// Function
// RULE_01 - Serves up to five rows by six columns, thirty keys.
// RULE_02 - Per-key and per-column masks exclude keys from detection and results; the key mask gates only results, not detection.
// RULE_03 - Idle with detection enabled: all unmasked columns driven high.
// RULE_04 - Any row going high pulls the active-low key event output low.
// RULE_05 - Key event output returns high when the following scan completes.
// RULE_06 - Event output stays high until host reads a result register.
// RULE_07 - Scan drives one column, others high impedance, samples and stores rows.
// RULE_08 - All pressed rows of the driven column are captured together.
// RULE_09 - Masked columns are neither driven, sampled nor loaded.
// RULE_10 - After detection wait the debounce interval, then scan all columns.
// RULE_11 - Host confirms scan completion before reading result registers.
// RULE_12 - No new scan until the host has read the previous results.
// RULE_13 - Reset held low at least 20 us; device resets while low.
// RULE_14 - Debounce and settling intervals are configurable clock counts.
//
// The address map and the Avalon-MM slave port were chosen for this implementation.
module kms_scanner #(
   parameter int DEBOUNCE_CYCLES = kms_pkg::DEBOUNCE_CYCLES,
   parameter int SETTLE_CYCLES = kms_pkg::SETTLE_CYCLES
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic device_reset_low,
   // Avalon-MM slave
   input wire logic [kms_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Keypad pins
   input wire logic [kms_pkg::ROWS-1:0] row_sense_lines,
   output logic [kms_pkg::COLS-1:0] column_drive_lines_out,
   output logic [kms_pkg::COLS-1:0] column_drive_lines_oe_n,
   output logic keypad_event_out_low,
   // Interrupt
   output logic irq
);

   localparam int ROWS = kms_pkg::ROWS;
   localparam int COLS = kms_pkg::COLS;
   localparam int KEYS = kms_pkg::KEYS;
   localparam int DEB_W = kms_pkg::DEB_W;
   localparam int SET_W = kms_pkg::SET_W;
   localparam int MASK_W = kms_pkg::MASK_W;
   localparam int RES_W = ROWS * kms_pkg::COLS_PER_RESULT;

   typedef enum logic [2:0] {
      KMS_IDLE,
      KMS_DEBOUNCE,
      KMS_NEXT_COL,
      KMS_SETTLE,
      KMS_DONE,
      KMS_WAIT_READ
   } kms_state_e;

   typedef struct packed {
      kms_state_e st;
      logic [2:0] col;
      logic enable;
      logic [DEB_W-1:0] debounce;
      logic [SET_W-1:0] settle;
      logic [KEYS-1:0] key_mask;
      logic [COLS-1:0] col_mask;
      logic [KEYS-1:0] result;
      logic [kms_pkg::ST_W-1:0] status;
      logic [kms_pkg::ST_W-1:0] irq_mask;
      logic [COLS-1:0] col_out;
      logic [COLS-1:0] col_oe_n;
      logic event_low;
      logic irq;
      logic waitreq;
      logic [31:0] rdata;
   } kms_top_s;

   kms_top_s s;
   kms_top_s next_s;

   logic [ROWS-1:0] rows;
   logic tmr_load;
   logic [DEB_W-1:0] tmr_value;
   logic tmr_done;

   if (DEBOUNCE_CYCLES < 1 || DEBOUNCE_CYCLES >= 2 ** DEB_W) begin : g_chk_deb
      $error("kms_scanner: debounce count does not fit the counter");
   end
   if (SETTLE_CYCLES < 1 || SETTLE_CYCLES >= 2 ** SET_W) begin : g_chk_set
      $error("kms_scanner: settle count does not fit the counter");
   end
   if (COLS > 8 || KEYS != 2 * RES_W) begin : g_chk_geo
      $error("kms_scanner: matrix geometry not supported");
   end

   // ==========================================================
   // Row synchroniser and interval timer
   kms_sync #(
      .W(ROWS)
   ) u_row_sync (
      .core_clk(core_clk),
      .device_reset_low(device_reset_low),
      .async_in(row_sense_lines),
      .sync_out(rows)
   );

   kms_timer #(
      .W(DEB_W)
   ) u_timer (
      .core_clk(core_clk),
      .device_reset_low(device_reset_low),
      .load(tmr_load),
      .load_value(tmr_value),
      .done(tmr_done)
   );

   // ==========================================================
   // Next state
   always_comb begin
      logic [31:0] rd;
      logic bus_req;
      logic do_write;
      logic do_read;
      logic result_read;
      logic [kms_pkg::ST_W-1:0] st_set;
      logic [ROWS-1:0] col_keys;
      rd = '0;
      bus_req = avs_read | avs_write;
      do_write = avs_write & ~s.waitreq;
      do_read = avs_read & ~s.waitreq;
      result_read = 1'b0;
      st_set = '0;
      col_keys = '0;
      tmr_load = 1'b0;
      tmr_value = '0;
      next_s = s;

      // Read mux
      unique case (avs_address)
         kms_pkg::REG_CTRL: rd[kms_pkg::CTRL_ENABLE_BIT] = s.enable;
         kms_pkg::REG_DEBOUNCE: rd[DEB_W-1:0] = s.debounce;
         kms_pkg::REG_SETTLE: rd[SET_W-1:0] = s.settle;
         kms_pkg::REG_KEY_MASK_LOW: rd[MASK_W-1:0] = s.key_mask[MASK_W-1:0];
         kms_pkg::REG_KEY_MASK_HIGH: rd[MASK_W-1:0] = s.key_mask[KEYS-1:MASK_W];
         kms_pkg::REG_COLUMN_MASK: rd[COLS-1:0] = s.col_mask;
         kms_pkg::REG_KEY_RESULT_FIRST: rd[RES_W-1:0] = s.result[RES_W-1:0];
         kms_pkg::REG_KEY_RESULT_SECOND: rd[RES_W-1:0] = s.result[KEYS-1:RES_W];
         kms_pkg::REG_STATUS: rd[kms_pkg::ST_W-1:0] = s.status;
         kms_pkg::REG_IRQ_MASK: rd[kms_pkg::ST_W-1:0] = s.irq_mask;
         kms_pkg::REG_STATE: begin
            rd[kms_pkg::STATE_BUSY_BIT] = (s.st != KMS_IDLE) && (s.st != KMS_WAIT_READ);
            rd[kms_pkg::STATE_WAIT_BIT] = (s.st == KMS_WAIT_READ);
            rd[kms_pkg::STATE_ROWS_LSB +: ROWS] = rows;
         end
         default: rd = '0;
      endcase

      // Bus handshake: one wait cycle, then the access completes
      next_s.waitreq = 1'b1;
      if (bus_req && s.waitreq) begin
         next_s.waitreq = 1'b0;
         next_s.rdata = rd;
      end

      if (do_write) begin
         unique case (avs_address)
            kms_pkg::REG_CTRL: next_s.enable = avs_writedata[kms_pkg::CTRL_ENABLE_BIT];
            kms_pkg::REG_DEBOUNCE: next_s.debounce = avs_writedata[DEB_W-1:0]; // RULE_14
            kms_pkg::REG_SETTLE: next_s.settle = avs_writedata[SET_W-1:0]; // RULE_14
            kms_pkg::REG_KEY_MASK_LOW: begin
               next_s.key_mask[MASK_W-1:0] = avs_writedata[MASK_W-1:0]; // RULE_02
            end
            kms_pkg::REG_KEY_MASK_HIGH: begin
               next_s.key_mask[KEYS-1:MASK_W] = avs_writedata[MASK_W-1:0]; // RULE_02
            end
            kms_pkg::REG_COLUMN_MASK: next_s.col_mask = avs_writedata[COLS-1:0]; // RULE_02
            kms_pkg::REG_IRQ_MASK: begin
               next_s.irq_mask = avs_writedata[kms_pkg::ST_W-1:0];
            end
            default: next_s.enable = s.enable;
         endcase
      end

      if (do_read) begin
         if (avs_address == kms_pkg::REG_STATUS) begin
            next_s.status = s.status & ~s.rdata[kms_pkg::ST_W-1:0];
         end
         if (avs_address == kms_pkg::REG_KEY_RESULT_FIRST ||
             avs_address == kms_pkg::REG_KEY_RESULT_SECOND) begin
            result_read = 1'b1;
         end
      end

      // Scan sequencer
      next_s.col_out = '0;
      next_s.col_oe_n = '1;
      unique case (s.st)
         KMS_IDLE: begin
            if (s.enable) begin
               next_s.col_out = ~next_s.col_mask; // RULE_03
               next_s.col_oe_n = next_s.col_mask; // RULE_02
               if (|rows) begin
                  next_s.event_low = 1'b0; // RULE_04
                  st_set[kms_pkg::ST_PRESS_BIT] = 1'b1;
                  tmr_load = 1'b1;
                  tmr_value = s.debounce; // RULE_10
                  next_s.st = KMS_DEBOUNCE;
               end
            end
         end
         KMS_DEBOUNCE: begin
            if (tmr_done) begin
               next_s.col = '0;
               next_s.st = KMS_NEXT_COL; // RULE_10
            end
         end
         KMS_NEXT_COL: begin
            if (s.col >= 3'(COLS)) begin
               next_s.st = KMS_DONE;
            end else if (s.col_mask[s.col]) begin
               next_s.col = s.col + 3'h1; // RULE_09
            end else begin
               next_s.col_out = COLS'(1) << s.col; // RULE_07
               next_s.col_oe_n = ~(COLS'(1) << s.col); // RULE_07
               tmr_load = 1'b1;
               tmr_value = DEB_W'(s.settle); // RULE_14
               next_s.st = KMS_SETTLE;
            end
         end
         KMS_SETTLE: begin
            next_s.col_out = s.col_out;
            next_s.col_oe_n = s.col_oe_n;
            if (tmr_done) begin
               for (int c = 0; c < COLS; c++) begin
                  if (3'(c) == s.col) begin
                     col_keys = rows & ~s.key_mask[c*ROWS +: ROWS]; // RULE_02
                     next_s.result[c*ROWS +: ROWS] = col_keys; // RULE_08
                  end
               end
               next_s.col_out = '0;
               next_s.col_oe_n = '1;
               next_s.col = s.col + 3'h1; // RULE_07
               next_s.st = KMS_NEXT_COL;
            end
         end
         KMS_DONE: begin
            next_s.event_low = 1'b1; // RULE_05
            st_set[kms_pkg::ST_DONE_BIT] = 1'b1;
            next_s.st = KMS_WAIT_READ;
         end
         KMS_WAIT_READ: begin
            if (result_read) begin
               next_s.st = KMS_IDLE; // RULE_06 RULE_12
            end
         end
         default: next_s.st = KMS_IDLE;
      endcase

      // Sticky events: a set in the clearing cycle wins
      next_s.status = next_s.status | st_set;
      next_s.irq = |(next_s.status & next_s.irq_mask);
   end

   // ==========================================================
   // Registers
   always_ff @(posedge core_clk) begin
      if (!device_reset_low) begin
         s <= '0; // RULE_13
         s.st <= KMS_IDLE;
         s.debounce <= DEB_W'(DEBOUNCE_CYCLES);
         s.settle <= SET_W'(SETTLE_CYCLES);
         s.col_oe_n <= '1;
         s.event_low <= 1'b1;
         s.waitreq <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // ==========================================================
   // Outputs
   assign avs_readdata = s.rdata;
   assign avs_waitrequest = s.waitreq;
   assign column_drive_lines_out = s.col_out; // RULE_01
   assign column_drive_lines_oe_n = s.col_oe_n;
   assign keypad_event_out_low = s.event_low;
   assign irq = s.irq;

endmodule // kms_scanner

// *** hw/kms_pkg.sv ***
// Shared constants of the keypad matrix scanner: matrix size, register map,
// field positions, reset values and timing figures.
// Assumes a single 200 MHz core clock and a 32-bit Avalon-MM register slave.
package kms_pkg;

   // ==========================================================
   // Matrix geometry
   localparam int ROWS = 5;
   localparam int COLS = 6;
   localparam int KEYS = ROWS * COLS;
   localparam int COLS_PER_RESULT = 3;

   // ==========================================================
   // Clock and timing
   localparam int CLK_MHZ = 200;
   localparam int DEBOUNCE_US = 20000;
   localparam int SETTLE_NS = 1000;
   localparam int RESET_MIN_US = 20;
   localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * CLK_MHZ;
   localparam int SETTLE_CYCLES = (SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam int RESET_MIN_CYCLES = RESET_MIN_US * CLK_MHZ;
   localparam int DEB_W = 24;
   localparam int SET_W = 16;

   // ==========================================================
   // Register map, byte addresses
   localparam int ADDR_W = 6;
   localparam logic [5:0] REG_CTRL = 6'h00;
   localparam logic [5:0] REG_DEBOUNCE = 6'h04;
   localparam logic [5:0] REG_SETTLE = 6'h08;
   localparam logic [5:0] REG_KEY_MASK_LOW = 6'h0c;
   localparam logic [5:0] REG_KEY_MASK_HIGH = 6'h10;
   localparam logic [5:0] REG_COLUMN_MASK = 6'h14;
   localparam logic [5:0] REG_KEY_RESULT_FIRST = 6'h18;
   localparam logic [5:0] REG_KEY_RESULT_SECOND = 6'h1c;
   localparam logic [5:0] REG_STATUS = 6'h20;
   localparam logic [5:0] REG_IRQ_MASK = 6'h24;
   localparam logic [5:0] REG_STATE = 6'h28;

   // ==========================================================
   // Field positions and reset values
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int ST_PRESS_BIT = 0;
   localparam int ST_DONE_BIT = 1;
   localparam int ST_W = 2;
   localparam int STATE_BUSY_BIT = 0;
   localparam int STATE_WAIT_BIT = 1;
   localparam int STATE_ROWS_LSB = 8;
   localparam int MASK_W = 15;
   localparam logic [DEB_W-1:0] DEBOUNCE_RESET = DEB_W'(DEBOUNCE_CYCLES);
   localparam logic [SET_W-1:0] SETTLE_RESET = SET_W'(SETTLE_CYCLES);

endpackage : kms_pkg

// *** hw/kms_sync.sv ***
// Two-flop synchroniser for a group of level inputs.
// Assumes inputs are asynchronous to core_clk; only the second stage is read.
module kms_sync #(
   parameter int W = 5
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic device_reset_low,
   // Data
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } kms_sync_s;

   kms_sync_s s;
   kms_sync_s next_s;

   if (W < 1) begin : g_chk
      $error("kms_sync: width must be at least one");
   end

   // ==========================================================
   // Next state
   always_comb begin
      next_s = s;
      next_s.meta = async_in;
      next_s.stable = s.meta;
   end

   // ==========================================================
   // Registers
   always_ff @(posedge core_clk) begin
      if (!device_reset_low) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign sync_out = s.stable;

endmodule // kms_sync

// *** hw/kms_timer.sv ***
// Load-and-expire interval counter in core_clk cycles.
// Assumes load is a one-cycle request; done pulses once per expired load.
module kms_timer #(
   parameter int W = 24
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic device_reset_low,
   // Control
   input wire logic load,
   input wire logic [W-1:0] load_value,
   output logic done
);

   typedef struct packed {
      logic [W-1:0] count;
      logic running;
      logic done;
   } kms_timer_s;

   kms_timer_s s;
   kms_timer_s next_s;

   if (W < 2) begin : g_chk
      $error("kms_timer: width must be at least two");
   end

   // ==========================================================
   // Next state
   always_comb begin
      next_s = s;
      next_s.done = 1'b0;
      if (load) begin
         next_s.count = (load_value == '0) ? W'(1) : load_value;
         next_s.running = 1'b1;
      end else if (s.running) begin
         if (s.count == W'(1)) begin
            next_s.running = 1'b0;
            next_s.done = 1'b1;
         end
         next_s.count = s.count - W'(1);
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge core_clk) begin
      if (!device_reset_low) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign done = s.done;

endmodule // kms_timer

// *** tb/kms_scanner_sva.sv ***
// Port checker of the keypad scanner: bus answer, column drive, event line.
// Assumes it is bound onto kms_scanner; one clock, synchronous low reset.
module kms_scanner_chk #(
   parameter int DEBOUNCE_CYCLES = 20
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic device_reset_low,
   // Bus
   input wire logic [kms_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic avs_waitrequest,
   // Pins
   input wire logic [kms_pkg::ROWS-1:0] row_sense_lines,
   input wire logic [kms_pkg::COLS-1:0] column_drive_lines_out,
   input wire logic [kms_pkg::COLS-1:0] column_drive_lines_oe_n,
   input wire logic keypad_event_out_low,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // Shadow of column mask, wait-for-read flag, low-time counter
   logic [5:0] cm;
   logic [5:0] cm_q;
   logic [5:0] drv;
   logic ev_q;
   logic hold;
   logic rd_res;
   logic [31:0] low_cnt;
   assign drv = ~column_drive_lines_oe_n;
   assign rd_res = avs_read && !avs_waitrequest &&
      (avs_address == kms_pkg::REG_KEY_RESULT_FIRST ||
      avs_address == kms_pkg::REG_KEY_RESULT_SECOND);
   always_ff @(posedge core_clk) begin
      if (!device_reset_low) begin
         cm <= '0;
         cm_q <= '0;
         ev_q <= 1'b1;
         hold <= 1'b0;
         low_cnt <= '0;
      end else begin
         if (avs_write && !avs_waitrequest && avs_address == kms_pkg::REG_COLUMN_MASK) begin
            cm <= avs_writedata[5:0];
         end
         cm_q <= cm;
         ev_q <= keypad_event_out_low;
         if (rd_res) begin
            hold <= 1'b0;
         end else if (!ev_q && keypad_event_out_low) begin
            hold <= 1'b1;
         end
         if (keypad_event_out_low) begin
            low_cnt <= '0;
         end else if (low_cnt != '1) begin
            low_cnt <= low_cnt + 32'h1;
         end
      end
   end
   // ==========================================================
   // Assertions
   property p_wait_answer;
      @(posedge core_clk) disable iff (!device_reset_low)
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_wait_answer: assert property (p_wait_answer) else $error("bus request not answered");
   property p_reset;
      @(posedge core_clk) !device_reset_low |=> keypad_event_out_low && avs_waitrequest && !irq
         && column_drive_lines_oe_n == 6'h3f;
   endproperty
   a_reset: assert property (p_reset) else $error("outputs not at reset level");
   property p_drive_high;
      @(posedge core_clk) disable iff (!device_reset_low) (drv & ~column_drive_lines_out) == 6'h00;
   endproperty
   a_drive_high: assert property (p_drive_high) else $error("column driven low");
   property p_masked;
      @(posedge core_clk) disable iff (!device_reset_low) (drv & cm & cm_q) == 6'h00;
   endproperty
   a_masked: assert property (p_masked) else $error("masked column driven");
   property p_one_or_all;
      @(posedge core_clk) disable iff (!device_reset_low) $countones(drv) <= 1 || (drv | cm | cm_q) == 6'h3f;
   endproperty
   a_one_or_all: assert property (p_one_or_all) else $error("bad column pattern");
   property p_hold;
      @(posedge core_clk) disable iff (!device_reset_low) hold |-> keypad_event_out_low;
   endproperty
   a_hold: assert property (p_hold) else $error("event before result read");
   property p_debounce;
      @(posedge core_clk) disable iff (!device_reset_low)
      $rose(keypad_event_out_low) |-> low_cnt >= DEBOUNCE_CYCLES;
   endproperty
   a_debounce: assert property (p_debounce) else $error("scan ended too soon");
   property p_detect;
      @(posedge core_clk) disable iff (!device_reset_low) $fell(keypad_event_out_low) |->
         $past(row_sense_lines, 2) != 5'h00 || $past(row_sense_lines, 3) != 5'h00;
   endproperty
   a_detect: assert property (p_detect) else $error("event without row");
endmodule // kms_scanner_chk

bind kms_scanner kms_scanner_chk #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_chk (
   .core_clk(core_clk), .device_reset_low(device_reset_low), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_waitrequest(avs_waitrequest),
   .row_sense_lines(row_sense_lines), .column_drive_lines_out(column_drive_lines_out),
   .column_drive_lines_oe_n(column_drive_lines_oe_n),
   .keypad_event_out_low(keypad_event_out_low), .irq(irq)
);

// *** tb/kms_keypad_model.sv ***
// Passive switch matrix: a pressed key ties its column line to its row line.
// Assumes rows are pulled down outside; undriven columns reach no row.
module kms_keypad_model (
   // Columns from the scanner
   input wire logic [kms_pkg::COLS-1:0] column_drive_lines_out,
   input wire logic [kms_pkg::COLS-1:0] column_drive_lines_oe_n,
   // Pressed keys, bit col*5+row
   input wire logic [kms_pkg::KEYS-1:0] pressed,
   // Rows to the scanner
   output logic [kms_pkg::ROWS-1:0] row_sense_lines
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // Row levels: pulled low unless a driven high column reaches them
   always_comb begin
      row_sense_lines = '0;
      for (int c = 0; c < kms_pkg::COLS; c++) begin
         for (int r = 0; r < kms_pkg::ROWS; r++) begin
            if (pressed[c*kms_pkg::ROWS+r] && !column_drive_lines_oe_n[c]
               && column_drive_lines_out[c]) begin
               row_sense_lines[r] = 1'b1;
            end
         end
      end
   end
endmodule // kms_keypad_model

// *** tb/tb_top.sv ***
// Testbench of the keypad scanner: bus tasks, keypad model, read-data queue.
// Assumes package, design, checker and keypad model compiled first.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DEB = 20;
   localparam int SET = 4;
   typedef struct {logic [5:0] a; logic [31:0] v;} kms_exp_s;
   logic core_clk = 1'b0;
   logic device_reset_low = 1'b0;
   logic [5:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = '0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [4:0] row_sense_lines;
   logic [5:0] column_drive_lines_out;
   logic [5:0] column_drive_lines_oe_n;
   logic keypad_event_out_low;
   logic irq;
   logic [29:0] pressed = '0;
   logic [29:0] km;
   logic [5:0] cm;
   logic [4:0] res [6] = '{default: 5'h00};
   kms_exp_s exp_q [$];
   kms_exp_s ent;
   int num_errors = 0;
   int check_count = 0;
   int cycles = 0;
   int r;
   always #2.5 core_clk = ~core_clk;
   kms_scanner #(.DEBOUNCE_CYCLES(DEB), .SETTLE_CYCLES(SET)) uut (
      .core_clk(core_clk), .device_reset_low(device_reset_low), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .row_sense_lines(row_sense_lines), .column_drive_lines_out(column_drive_lines_out),
      .column_drive_lines_oe_n(column_drive_lines_oe_n),
      .keypad_event_out_low(keypad_event_out_low), .irq(irq));
   kms_keypad_model u_keys (.column_drive_lines_out(column_drive_lines_out),
      .column_drive_lines_oe_n(column_drive_lines_oe_n), .pressed(pressed),
      .row_sense_lines(row_sense_lines));
   // ==========================================================
   // Compare, bus and wait tasks
   task automatic check_rd(input logic [5:0] a, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch reg %h expected %h seen %h", a, e, g);
      end
   endtask
   task automatic check_pin(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      @(posedge core_clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] a, input logic [31:0] v);
      exp_q.push_back('{a, v});
      bus(1'b0, a, 32'h0);
   endtask
   task automatic wait_ev(input logic v, input int lim);
      int n;
      n = 0;
      while (keypad_event_out_low !== v && n < lim) begin
         @(posedge core_clk);
         n++;
      end
      check_pin("event line", {31'h0, v}, {31'h0, keypad_event_out_low});
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // ==========================================================
   // Read-data monitor and timeout
   always @(posedge core_clk) begin
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
         ent = exp_q.pop_front();
         check_rd(ent.a, ent.v, avs_readdata);
      end
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         conclude();
      end
   end
   // ==========================================================
   // Main sequence
   initial begin
      void'($urandom(32'h912a5e87));
      repeat (5) @(posedge core_clk);
      device_reset_low <= 1'b1;
      check_pin("oe_n", 32'h3f, {26'h0, column_drive_lines_oe_n});
      rd(kms_pkg::REG_CTRL, 32'h0);
      rd(kms_pkg::REG_COLUMN_MASK, 32'h0);
      rd(6'h3c, 32'h0);
      bus(1'b1, kms_pkg::REG_DEBOUNCE, 32'(DEB));
      bus(1'b1, kms_pkg::REG_SETTLE, 32'(SET));
      rd(kms_pkg::REG_DEBOUNCE, 32'(DEB));
      bus(1'b1, kms_pkg::REG_CTRL, 32'h1);
      for (int i = 0; i < 6; i++) begin
         r = $urandom_range(4, 0);
         cm = (i == 0) ? 6'h00 : 6'($urandom()) & ~(6'h01 << i);
         km = (i == 0) ? 30'h0 : 30'($urandom()) & ~(30'h1 << (i * 5 + r));
         bus(1'b1, kms_pkg::REG_KEY_MASK_LOW, {17'h0, km[14:0]});
         bus(1'b1, kms_pkg::REG_KEY_MASK_HIGH, {17'h0, km[29:15]});
         bus(1'b1, kms_pkg::REG_COLUMN_MASK, {26'h0, cm});
         bus(1'b1, kms_pkg::REG_IRQ_MASK, (i % 2 == 0) ? 32'h3 : 32'h0);
         repeat (3) @(posedge core_clk);
         check_pin("oe_n idle", {26'h0, cm}, {26'h0, column_drive_lines_oe_n});
         check_pin("col idle", {26'h0, ~cm}, {26'h0, column_drive_lines_out});
         pressed <= 30'($urandom()) | (30'h1 << (i * 5 + r));
         wait_ev(1'b0, 20);
         wait_ev(1'b1, 200);
         for (int c = 0; c < 6; c++) begin
            if (!cm[c]) res[c] = pressed[c*5+:5] & ~km[c*5+:5];
         end
         repeat (40) @(posedge core_clk);
         check_pin("event held", 32'h1, {31'h0, keypad_event_out_low});
         check_pin("oe_n waiting", 32'h3f, {26'h0, column_drive_lines_oe_n});
         rd(kms_pkg::REG_STATE, 32'h2);
         check_pin("irq", {31'h0, i % 2 == 0}, {31'h0, irq});
         rd(kms_pkg::REG_STATUS, 32'h3);
         repeat (3) @(posedge core_clk);
         check_pin("irq clear", 32'h0, {31'h0, irq});
         pressed <= '0;
         repeat (4) @(posedge core_clk);
         rd(kms_pkg::REG_KEY_RESULT_FIRST, {17'h0, res[2], res[1], res[0]});
         rd(kms_pkg::REG_KEY_RESULT_SECOND, {17'h0, res[5], res[4], res[3]});
      end
      bus(1'b1, kms_pkg::REG_CTRL, 32'h0);
      repeat (4) @(posedge core_clk);
      check_pin("oe_n off", 32'h3f, {26'h0, column_drive_lines_oe_n});
      conclude();
   end
endmodule // tb_top
